// *** hdl/dsc_defines.svh ***
// Constants for the divider alignment control block and its host controller
// ============================================================================
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// ============================================================================
// Device register offsets and fields
`define DSC_OFS_OUTPUT_MODE     13'h0014
`define DSC_OFS_SIG_LOW         13'h0024
`define DSC_OFS_SIG_HIGH        13'h0025
`define DSC_OFS_NOISE_INJ       13'h0030
`define DSC_OFS_DIV_ALIGN       13'h0100
`define DSC_RST_BYTE            8'h00
`define DSC_BIT_MASTER_EN       0
`define DSC_BIT_DIVIDER_EN      1
`define DSC_BIT_ONE_SHOT        2
`define DSC_BIT_NOISE_INJ       4
`define DSC_BIT_OUT_DISABLE     4
`define DSC_BIT_OUT_LVDS        6
`define DSC_OUT_MODE_WMASK      8'hF7

// ============================================================================
// Serial frame layout: read flag, two length bits, 13 address bits, one byte
`define DSC_FRAME_BITS          5'h18
`define DSC_CMD_LAST            5'h0F
`define DSC_FRAME_LAST          5'h17

// ============================================================================
// Host controller register offsets and fields
`define DSC_H_OFS_ADDR          12'h000
`define DSC_H_OFS_WDATA         12'h004
`define DSC_H_OFS_CTRL          12'h008
`define DSC_H_OFS_STATUS        12'h00C
`define DSC_H_CTRL_WRITE        0
`define DSC_H_CTRL_READ         1
`define DSC_H_CTRL_DISABLE      2
`define DSC_H_CTRL_SYNC         3
`define DSC_H_DISABLE_RST       1'b1

// ============================================================================
// Timing: 250 MHz system clock
`define DSC_CLK_PERIOD_PS       4000
`define DSC_SCLK_HALF_NS        16
`define DSC_SCLK_HALF_CYC       (((`DSC_SCLK_HALF_NS * 1000) + `DSC_CLK_PERIOD_PS - 1) / `DSC_CLK_PERIOD_PS)
`define DSC_SYNC_WIDTH_NS       8
`define DSC_SYNC_WIDTH_CYC      (((`DSC_SYNC_WIDTH_NS * 1000) + `DSC_CLK_PERIOD_PS - 1) / `DSC_CLK_PERIOD_PS)

`endif

// *** hdl/dsc_device.sv ***
// Device end: serial register port, divider alignment and output mode control
`timescale 1ns/1ps
`include "dsc_defines.svh"
module dsc_device (
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // Link to the host controller
    dsc_link_if.device       link,
    // Self-test engine
    input  wire logic [15:0] built_in_self_test_signature_in,
    // Converter controls
    output logic             divider_realign_out,
    output logic             lvds_mode_out,
    output logic             data_output_enable_out,
    output logic             noise_injection_enable_out
);

    // ========================================================================
    // Serial receiver state
    dsc_pkg::dsc_dev_state_e state;
    dsc_pkg::dsc_dev_state_e next_state;
    logic [4:0]              cnt;
    logic [4:0]              next_cnt;
    logic [15:0]             shift;
    logic [15:0]             next_shift;
    logic [15:0]             cmd;
    logic [15:0]             next_cmd;
    dsc_pkg::dsc_byte_t      rd_shift;
    dsc_pkg::dsc_byte_t      next_rd_shift;
    logic                    rd_drive;
    logic                    next_rd_drive;
    logic                    sclk_q;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    write_stb;
    dsc_pkg::dsc_byte_t      write_data;

    // ========================================================================
    // Configuration state
    logic [2:0]              div_align;
    logic [2:0]              next_div_align;
    logic                    noise_inj;
    logic                    next_noise_inj;
    dsc_pkg::dsc_byte_t      out_mode;
    dsc_pkg::dsc_byte_t      next_out_mode;
    logic                    sync_q;
    logic                    sync_rise;
    logic                    realign;
    logic                    next_lvds;
    logic                    next_out_en;

    // Read value of a register; unmapped and reserved bits read zero
    function automatic dsc_pkg::dsc_byte_t read_value(input dsc_pkg::dsc_addr_t addr);
        dsc_pkg::dsc_byte_t v;
        v = `DSC_RST_BYTE;
        unique case (addr)
            `DSC_OFS_OUTPUT_MODE: v = out_mode;
            `DSC_OFS_SIG_LOW:     v = built_in_self_test_signature_in[7:0];
            `DSC_OFS_SIG_HIGH:    v = built_in_self_test_signature_in[15:8];
            `DSC_OFS_NOISE_INJ:   v[`DSC_BIT_NOISE_INJ] = noise_inj;
            `DSC_OFS_DIV_ALIGN:   v[2:0] = div_align;
            default:              v = `DSC_RST_BYTE;
        endcase
        return v;
    endfunction

    // Edge detection on the serial clock and alignment pulse
    assign sclk_rise = link.sclk & ~sclk_q;
    assign sclk_fall = ~link.sclk & sclk_q;
    assign sync_rise = link.sync_pulse & ~sync_q;

    // ========================================================================
    // Serial receiver next state
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_shift    = shift;
        next_cmd      = cmd;
        next_rd_shift = rd_shift;
        next_rd_drive = rd_drive;
        write_stb     = 1'b0;
        write_data    = {shift[6:0], link.sdio};
        if (link.csb_n) begin
            // Frame select high aborts any frame
            next_state    = dsc_pkg::DSC_DEV_CMD;
            next_cnt      = 5'h00;
            next_rd_drive = 1'b0;
        end else begin
            unique case (state)
                dsc_pkg::DSC_DEV_CMD: begin
                    if (sclk_rise) begin
                        next_shift = {shift[14:0], link.sdio};
                        next_cnt   = cnt + 5'h01;
                        if (cnt == `DSC_CMD_LAST) begin
                            next_cmd = {shift[14:0], link.sdio};
                            if (shift[14]) begin
                                next_state    = dsc_pkg::DSC_DEV_RDATA;
                                next_rd_shift = read_value({shift[11:0], link.sdio});
                            end else begin
                                next_state = dsc_pkg::DSC_DEV_WDATA;
                            end
                        end
                    end
                end
                dsc_pkg::DSC_DEV_WDATA: begin
                    if (sclk_rise) begin
                        next_shift = {shift[14:0], link.sdio};
                        next_cnt   = cnt + 5'h01;
                        if (cnt == `DSC_FRAME_LAST) begin
                            write_stb  = 1'b1;
                            next_state = dsc_pkg::DSC_DEV_IGNORE;
                        end
                    end
                end
                dsc_pkg::DSC_DEV_RDATA: begin
                    // Take the line at the first falling edge, shift after each rise
                    if (sclk_fall && !rd_drive) begin
                        next_rd_drive = 1'b1;
                    end
                    if (sclk_rise && rd_drive) begin
                        next_rd_shift = {rd_shift[6:0], 1'b0};
                        next_cnt      = cnt + 5'h01;
                        if (cnt == `DSC_FRAME_LAST) begin
                            next_rd_drive = 1'b0;
                            next_state    = dsc_pkg::DSC_DEV_IGNORE;
                        end
                    end
                end
                dsc_pkg::DSC_DEV_IGNORE: begin
                    next_state = dsc_pkg::DSC_DEV_IGNORE;
                end
            endcase
        end
    end

    // Serial receiver registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state    <= dsc_pkg::DSC_DEV_CMD;
            cnt      <= 5'h00;
            shift    <= 16'h0000;
            cmd      <= 16'h0000;
            rd_shift <= 8'h00;
            rd_drive <= 1'b0;
            sclk_q   <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            shift    <= next_shift;
            cmd      <= next_cmd;
            rd_shift <= next_rd_shift;
            rd_drive <= next_rd_drive;
            sclk_q   <= link.sclk;
        end
    end

    assign link.dev_sdio_out = rd_shift[7];
    assign link.dev_sdio_oe  = rd_drive;

    // ========================================================================
    // Alignment and configuration next state
    always_comb begin
        realign        = sync_rise & div_align[`DSC_BIT_MASTER_EN]
                         & div_align[`DSC_BIT_DIVIDER_EN];
        next_div_align = div_align;
        next_noise_inj = noise_inj;
        next_out_mode  = out_mode;
        if (realign && div_align[`DSC_BIT_ONE_SHOT]) begin
            next_div_align[`DSC_BIT_DIVIDER_EN] = 1'b0;
        end
        // A software write in the same cycle takes precedence
        if (write_stb) begin
            unique case (cmd[12:0])
                `DSC_OFS_DIV_ALIGN:   next_div_align = write_data[2:0];
                `DSC_OFS_NOISE_INJ:   next_noise_inj = write_data[`DSC_BIT_NOISE_INJ];
                `DSC_OFS_OUTPUT_MODE: next_out_mode  = write_data & `DSC_OUT_MODE_WMASK;
                default:              next_out_mode  = out_mode;
            endcase
        end
        next_lvds   = out_mode[`DSC_BIT_OUT_LVDS];
        next_out_en = ~link.output_disable_pin
                      & ~out_mode[`DSC_BIT_OUT_DISABLE];
    end

    // Alignment and configuration registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_align                  <= 3'h0;
            noise_inj                  <= 1'b0;
            out_mode                   <= `DSC_RST_BYTE;    // CMOS after power-up
            sync_q                     <= 1'b0;
            divider_realign_out        <= 1'b0;
            lvds_mode_out              <= 1'b0;
            data_output_enable_out     <= 1'b0;             // Disabled during reset
            noise_injection_enable_out <= 1'b0;
        end else begin
            div_align                  <= next_div_align;
            noise_inj                  <= next_noise_inj;
            out_mode                   <= next_out_mode;
            sync_q                     <= link.sync_pulse;
            divider_realign_out        <= realign;
            lvds_mode_out              <= next_lvds;
            data_output_enable_out     <= next_out_en;
            noise_injection_enable_out <= noise_inj;
        end
    end

endmodule

// *** hdl/dsc_host.sv ***
// Host end: APB slave registers driving the serial port, alignment pulse and disable pin
`timescale 1ns/1ps
`include "dsc_defines.svh"
module dsc_host (
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link to the device
    dsc_link_if.host         link
);

    // ========================================================================
    // State
    dsc_pkg::dsc_host_state_e state;
    dsc_pkg::dsc_host_state_e next_state;
    dsc_pkg::dsc_addr_t       addr;
    dsc_pkg::dsc_addr_t       next_addr;
    dsc_pkg::dsc_byte_t       wdata;
    dsc_pkg::dsc_byte_t       next_wdata;
    dsc_pkg::dsc_byte_t       rdata;
    dsc_pkg::dsc_byte_t       next_rdata;
    logic                     disable_lvl;
    logic                     next_disable_lvl;
    logic [23:0]              tx;
    logic [23:0]              next_tx;
    logic [4:0]               bit_cnt;
    logic [4:0]               next_bit_cnt;
    logic [3:0]               half;
    logic [3:0]               next_half;
    logic                     is_read;
    logic                     next_is_read;
    logic [3:0]               sync_cnt;
    logic [3:0]               next_sync_cnt;
    logic                     sclk;
    logic                     next_sclk;
    logic                     csb_n;
    logic                     next_csb_n;
    logic                     sdio_oe;
    logic                     next_sdio_oe;
    logic                     wr_en;
    logic                     busy;

    assign wr_en   = psel & penable & pwrite;
    assign busy    = (state != dsc_pkg::DSC_HOST_IDLE);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (paddr != `DSC_H_OFS_ADDR) & (paddr != `DSC_H_OFS_WDATA)
                     & (paddr != `DSC_H_OFS_CTRL) & (paddr != `DSC_H_OFS_STATUS);

    // Read data mux
    always_comb begin
        unique case (paddr)
            `DSC_H_OFS_ADDR:   prdata = {19'h00000, addr};
            `DSC_H_OFS_WDATA:  prdata = {24'h000000, wdata};
            `DSC_H_OFS_CTRL:   prdata = {29'h00000000, disable_lvl, 2'h0};
            `DSC_H_OFS_STATUS: prdata = {16'h0000, rdata, 7'h00, busy};
            default:           prdata = 32'h00000000;
        endcase
    end

    // ========================================================================
    // Next state: registers, serial frame and alignment pulse
    always_comb begin
        next_state       = state;
        next_addr        = addr;
        next_wdata       = wdata;
        next_rdata       = rdata;
        next_disable_lvl = disable_lvl;
        next_tx          = tx;
        next_bit_cnt     = bit_cnt;
        next_half        = half;
        next_is_read     = is_read;
        next_sync_cnt    = (sync_cnt != 4'h0) ? sync_cnt - 4'h1 : 4'h0;
        next_sclk        = sclk;
        next_csb_n       = csb_n;
        next_sdio_oe     = sdio_oe;
        if (wr_en) begin
            unique case (paddr)
                `DSC_H_OFS_ADDR:  next_addr  = pwdata[12:0];
                `DSC_H_OFS_WDATA: next_wdata = pwdata[7:0];
                `DSC_H_OFS_CTRL: begin
                    next_disable_lvl = pwdata[`DSC_H_CTRL_DISABLE];
                    if (pwdata[`DSC_H_CTRL_SYNC] && sync_cnt == 4'h0) begin
                        next_sync_cnt = 4'(`DSC_SYNC_WIDTH_CYC);
                    end
                end
                default: next_addr = addr;
            endcase
        end
        unique case (state)
            dsc_pkg::DSC_HOST_IDLE: begin
                // Frames start only on request, so the port idles otherwise
                if (wr_en && paddr == `DSC_H_OFS_CTRL
                    && (pwdata[`DSC_H_CTRL_WRITE] || pwdata[`DSC_H_CTRL_READ])) begin
                    next_is_read = pwdata[`DSC_H_CTRL_READ];
                    next_tx      = {pwdata[`DSC_H_CTRL_READ], 2'b00, addr, wdata};
                    next_bit_cnt = 5'h00;
                    next_half    = 4'(`DSC_SCLK_HALF_CYC);
                    next_csb_n   = 1'b0;
                    next_sdio_oe = 1'b1;
                    next_state   = dsc_pkg::DSC_HOST_LOW;
                end
            end
            dsc_pkg::DSC_HOST_LOW: begin
                next_half = half - 4'h1;
                if (half == 4'h1) begin
                    if (is_read && bit_cnt > `DSC_CMD_LAST) begin
                        next_rdata = {rdata[6:0], link.sdio};
                    end
                    next_sclk  = 1'b1;
                    next_half  = 4'(`DSC_SCLK_HALF_CYC);
                    next_state = dsc_pkg::DSC_HOST_HIGH;
                end
            end
            dsc_pkg::DSC_HOST_HIGH: begin
                next_half = half - 4'h1;
                if (half == 4'h1) begin
                    next_sclk    = 1'b0;
                    next_half    = 4'(`DSC_SCLK_HALF_CYC);
                    next_bit_cnt = bit_cnt + 5'h01;
                    next_tx      = {tx[22:0], 1'b0};
                    if (is_read && bit_cnt >= `DSC_CMD_LAST) begin
                        next_sdio_oe = 1'b0;
                    end
                    next_state = (bit_cnt == `DSC_FRAME_LAST) ? dsc_pkg::DSC_HOST_END
                                                              : dsc_pkg::DSC_HOST_LOW;
                end
            end
            dsc_pkg::DSC_HOST_END: begin
                next_half = half - 4'h1;
                next_sdio_oe = 1'b0;
                if (half == 4'h1) begin
                    next_csb_n = 1'b1;
                    next_state = dsc_pkg::DSC_HOST_IDLE;
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state       <= dsc_pkg::DSC_HOST_IDLE;
            addr        <= 13'h0000;
            wdata       <= 8'h00;
            rdata       <= 8'h00;
            disable_lvl <= `DSC_H_DISABLE_RST;      // Outputs held off from power-up
            tx          <= 24'h000000;
            bit_cnt     <= 5'h00;
            half        <= 4'h0;
            is_read     <= 1'b0;
            sync_cnt    <= 4'h0;
            sclk        <= 1'b0;
            csb_n       <= 1'b1;
            sdio_oe     <= 1'b0;
        end else begin
            state       <= next_state;
            addr        <= next_addr;
            wdata       <= next_wdata;
            rdata       <= next_rdata;
            disable_lvl <= next_disable_lvl;
            tx          <= next_tx;
            bit_cnt     <= next_bit_cnt;
            half        <= next_half;
            is_read     <= next_is_read;
            sync_cnt    <= next_sync_cnt;
            sclk        <= next_sclk;
            csb_n       <= next_csb_n;
            sdio_oe     <= next_sdio_oe;
        end
    end

    // Link pins
    assign link.sclk               = sclk;
    assign link.csb_n              = csb_n;
    assign link.host_sdio_out      = tx[23];
    assign link.host_sdio_oe       = sdio_oe;
    assign link.sync_pulse         = (sync_cnt != 4'h0);
    assign link.output_disable_pin = disable_lvl;

endmodule

// *** hdl/dsc_link_if.sv ***
// Link between the host controller and the divider alignment device
`timescale 1ns/1ps
interface dsc_link_if;
    logic sclk;                 // Serial clock, made by the host
    logic csb_n;                // Serial frame select, active low
    logic host_sdio_out;
    logic host_sdio_oe;
    logic dev_sdio_out;
    logic dev_sdio_oe;
    logic sdio;                 // Resolved data line, pulled high when idle
    logic sync_pulse;           // Alignment pulse, made by the host on a control register request
    logic output_disable_pin;   // High disables the data outputs

    // Resolve the shared data line from the enables
    assign sdio = host_sdio_oe ? host_sdio_out : (dev_sdio_oe ? dev_sdio_out : 1'b1);

    modport device (
        input  sclk, csb_n, sdio, sync_pulse, output_disable_pin,
        output dev_sdio_out, dev_sdio_oe
    );
    modport host (
        input  sdio,
        output sclk, csb_n, host_sdio_out, host_sdio_oe, sync_pulse, output_disable_pin
    );
endinterface

// *** hdl/dsc_pkg.sv ***
// Types shared by the divider alignment device and its host controller
package dsc_pkg;

    // Device serial receiver states
    typedef enum logic [3:0] {
        DSC_DEV_CMD    = 4'h1,
        DSC_DEV_WDATA  = 4'h2,
        DSC_DEV_RDATA  = 4'h4,
        DSC_DEV_IGNORE = 4'h8
    } dsc_dev_state_e;

    // Host serial transmitter states
    typedef enum logic [3:0] {
        DSC_HOST_IDLE = 4'h1,
        DSC_HOST_LOW  = 4'h2,
        DSC_HOST_HIGH = 4'h4,
        DSC_HOST_END  = 4'h8
    } dsc_host_state_e;

    typedef logic [7:0]  dsc_byte_t;
    typedef logic [12:0] dsc_addr_t;

endpackage

// *** tb/dsc_properties.sv ***
// Checker of the serial link, alignment pulse and device outputs
`timescale 1ns/1ps
module dsc_properties (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Link and device outputs
    input wire logic sclk,
    input wire logic csb_n,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_oe,
    input wire logic sync_pulse,
    input wire logic output_disable_pin,
    input wire logic divider_realign_out,
    input wire logic lvds_mode_out,
    input wire logic data_output_enable_out
);
    // ========================================================================
    // Assertions on the system clock
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_two_high;
        sync_pulse ##1 !sync_pulse;
    endsequence
    property p_sync_width; $rose(sync_pulse) |=> s_two_high; endproperty
    a_sync_width: assert property (p_sync_width) else $error("sync width");
    property p_once; divider_realign_out |=> !divider_realign_out [*3]; endproperty
    a_once: assert property (p_once) else $error("double realign");
    property p_cause; divider_realign_out |-> $past(sync_pulse) || $past(sync_pulse, 2); endproperty
    a_cause: assert property (p_cause) else $error("realign without pulse");
    property p_off; output_disable_pin [*2] |-> !data_output_enable_out; endproperty
    a_off: assert property (p_off) else $error("outputs on while disabled");
    property p_mode; $changed(lvds_mode_out) |-> !csb_n; endproperty
    a_mode: assert property (p_mode) else $error("mode change outside frame");
    property p_idle; csb_n |-> !sclk && !host_sdio_oe && !dev_sdio_oe; endproperty
    a_idle: assert property (p_idle) else $error("link busy when idle");
    property p_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
    a_half: assert property (p_half) else $error("serial clock high time");
    property p_drive; !(host_sdio_oe && dev_sdio_oe); endproperty
    a_drive: assert property (p_drive) else $error("data line contention");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the host controller and device pair
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t bad %h", $time, a); end end
module tb_top;
    // ========================================================================
    // Signals
    logic        clk_sys_in = 0;
    logic        rst_n_in = 0;
    logic        psel = 0, penable = 0, pwrite = 0, dis = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'hAFA4;
    logic        pready, pslverr, e, realign, lvds, oen, noise;
    logic [15:0] sig = 16'h0000;
    logic [7:0]  q, w8;
    int          error_cnt = 0, n_tests = 0, cyc = 0, rcnt = 0, exp_n;
    int          mreg [int];        // Model of the device registers, by address
    dsc_link_if link ();
    dsc_host i_dsc_host (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    dsc_device i_dsc_device (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(link),
        .built_in_self_test_signature_in(sig), .divider_realign_out(realign),
        .lvds_mode_out(lvds), .data_output_enable_out(oen), .noise_injection_enable_out(noise));
    dsc_properties i_dsc_properties (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .sclk(link.sclk), .csb_n(link.csb_n), .host_sdio_oe(link.host_sdio_oe),
        .dev_sdio_oe(link.dev_sdio_oe), .sync_pulse(link.sync_pulse),
        .output_disable_pin(link.output_disable_pin), .divider_realign_out(realign),
        .lvds_mode_out(lvds), .data_output_enable_out(oen));
    // Clock, realign counter and run limit
    always #2 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc++;
        if (realign === 1'h1) rcnt++;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // One APB transfer; read data and error kept in r and e
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'h1;
        @(posedge clk_sys_in);
        while (pready !== 1'h1) @(posedge clk_sys_in);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Register model: what a serial write leaves in each device register
    task mw(input int a, input int d);
        if (a == 32'h100) mreg[a] = d & 32'h7;
        if (a == 32'h30) mreg[a] = d & 32'h10;
        if (a == 32'h14) mreg[a] = d & 32'hF7;
    endtask
    // One serial frame, waiting for busy to clear; read byte in q
    task ser(input logic rd, input logic [12:0] a, input logic [7:0] d);
        if (!rd) mw(a, d);
        apb(1'h1, 12'h000, {19'h0, a});
        apb(1'h1, 12'h004, {24'h0, d});
        apb(1'h1, 12'h008, {29'h0, dis, rd, !rd});
        r = 32'h1;
        while (r[0] !== 1'h0) apb(1'h0, 12'h00C, 32'h0);
        q = r[15:8];
    endtask
    task pulse();
        // Model: both enables realign; one-shot then clears the gate bit
        if ((mreg[32'h100] & 32'h3) == 32'h3) begin
            exp_n++;
            if ((mreg[32'h100] & 32'h4) != 32'h0) mreg[32'h100] -= 32'h2;
        end
        apb(1'h1, 12'h008, {28'h0, 1'h1, dis, 2'h0});
        repeat (8) @(posedge clk_sys_in);
    endtask
    task conclude();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        r = rnd();
        sig <= r[15:0];
        mreg[32'h14] = 32'h0;
        mreg[32'h24] = r[7:0];
        mreg[32'h25] = r[15:8];
        mreg[32'h30] = 32'h0;
        mreg[32'h100] = 32'h0;
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        @(posedge clk_sys_in);
        `CHK(lvds, 1'h0)
        `CHK(oen, 1'h0)
        ser(1'h0, 13'h0025, 8'hFF);
        ser(1'h1, 13'h0025, 8'h00);
        `CHK(q, mreg[32'h25])
        ser(1'h1, 13'h0024, 8'h00);
        `CHK(q, mreg[32'h24])
        for (int v = 0; v < 8; v++) begin
            ser(1'h0, 13'h0100, v[7:0]);
            rcnt = 0;
            exp_n = 0;
            pulse();
            pulse();
            `CHK(rcnt, exp_n)
            ser(1'h1, 13'h0100, 8'h00);
            `CHK(q, mreg[32'h100])
        end
        repeat (3) begin
            r = rnd();
            w8 = r[7:0];
            ser(1'h0, 13'h0030, w8);
            `CHK(noise, w8[4])
            ser(1'h1, 13'h0030, 8'h00);
            `CHK(q, mreg[32'h30])
        end
        ser(1'h0, 13'h0014, 8'h40);
        `CHK(lvds, 1'h1)
        `CHK(oen, 1'h0)
        for (int k = 0; k < 2; k++) begin
            dis = k[0];
            apb(1'h1, 12'h008, {29'h0, dis, 2'h0});
            repeat (3) @(posedge clk_sys_in);
            `CHK(oen, !dis)
        end
        // Output-off bit and write mask of the output mode register, pin released
        dis = 1'h0;
        for (int k = 0; k < 2; k++) begin
            ser(1'h0, 13'h0014, k[0] ? 8'h40 : 8'h58);
            ser(1'h1, 13'h0014, 8'h00);
            `CHK(q, mreg[32'h14])
            `CHK(oen, k[0])
        end
        // Master enable left low once alignment is no longer used
        ser(1'h0, 13'h0100, 8'h00);
        ser(1'h1, 13'h0100, 8'h00);
        `CHK(q, mreg[32'h100])
        apb(1'h0, 12'h010, 32'h0);
        `CHK(e, 1'h1)
        `CHK(r, 32'h0)
        conclude();
    end
endmodule
